/* File: src/crpc_consts.svh */
`ifndef CRPC_CONSTS_SVH
`define CRPC_CONSTS_SVH
// Register byte offsets
`define CRPC_OFF_CLKCFG    12'h000
`define CRPC_OFF_PWRCTL    12'h004
`define CRPC_OFF_AUX       12'h008
`define CRPC_OFF_T2CTL     12'h00c
`define CRPC_OFF_T2MODE    12'h010
`define CRPC_OFF_T2RELOAD  12'h014
`define CRPC_OFF_STATUS    12'h018
`define CRPC_OFF_WAKE      12'h01c
// Field positions
`define CRPC_BIT_DSEL      0
`define CRPC_BIT_IDLE      0
`define CRPC_BIT_PDOWN     1
`define CRPC_BIT_POF       4
`define CRPC_BIT_LOW_POWER_PROM_BIT      4
`define CRPC_BIT_T2CT      1
`define CRPC_BIT_T2RUN     2
`define CRPC_BIT_CLKOUT_OUTPUT_ENABLE      1
// Timing
`define CRPC_CYC_FAST      4'd6
`define CRPC_CYC_SLOW      4'd12
`define CRPC_RST_MCYC      2'd2
`define CRPC_STALL_MCYC    2'd2
`endif

/* File: src/crpc_pkg.sv */
package crpc_pkg;
  typedef enum logic [2:0] {
    CRPC_RUN,
    CRPC_IDLE,
    CRPC_PDOWN,
    CRPC_WAKE,
    CRPC_STALL
  } crpc_state_t;
endpackage : crpc_pkg

/* File: src/crpc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "crpc_consts.svh"
module crpc_top #(
  parameter int RELOAD_W = 16
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 por_n,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Device pins
  input  wire logic                 reset_pin,
  input  wire logic                 double_speed_fuse,
  input  wire logic                 external_access_strap,
  input  wire logic                 ale_pin_in,
  input  wire logic                 program_store_strobe_in,
  input  wire logic                 ext_irq_pin_zero,
  input  wire logic                 ext_irq_pin_one,
  // Interrupt controller side
  input  wire logic [1:0]           ext_irq_enable,
  input  wire logic [1:0]           ext_irq_level_mode,
  input  wire logic                 irq_pending,
  // Core and peripheral controls
  output logic                      mcycle_en,
  output logic                      serial_fixed_en,
  output logic                      cpu_run,
  output logic                      ram_access_block,
  output logic                      osc_enable,
  output logic                      core_reset,
  output logic                      ports_reset_force,
  output logic                      ea_latched,
  output logic                      test_mode,
  output logic                      port0_float,
  output logic                      weak_pullup_en,
  output logic                      prom_analog_off,
  output logic                      t2_irq_suppress,
  // Clock-out pin, port 1 bit 0
  output logic                      clkout_o,
  output logic                      clkout_oe
);
  import crpc_pkg::*;

  // State and control registers
  crpc_state_t         st_q;
  logic                dsel_q;
  logic                pof_q;
  logic                low_power_prom_bit_q;
  logic                t2ct_q;
  logic                t2run_q;
  logic                clkout_output_enable_q;
  logic [RELOAD_W-1:0] reload_q;
  logic [RELOAD_W-1:0] t2cnt_q;
  logic [3:0]          div_q;
  logic                half_q;
  logic [1:0]          rcnt_q;
  logic                rst_int_q;
  logic                rst_prev_q;
  logic                test_q;
  logic                ea_q;
  logic                clk_q;
  logic [1:0]          stall_q;
  // Combinational helpers
  logic                fast;
  logic [3:0]          div_lim;
  logic                wr;
  logic                rd;
  logic                mc;
  logic                wake_low;
  logic                wake_high;
  logic                clkout_mode;
  logic [1:0]          irq_pin_lvl;
  logic [1:0]          pin_low;
  logic [1:0]          pin_clear;

  // Resolved clock mode
  assign fast    = double_speed_fuse | dsel_q;
  assign div_lim = fast ? `CRPC_CYC_FAST : `CRPC_CYC_SLOW;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign mc      = (div_q == div_lim - 4'd1) & osc_enable;

  // Machine-cycle divider, halted while oscillator is off
  // Freezing the count keeps the cycle phase across power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 4'd0;
    end else if (!osc_enable) begin
      div_q <= div_q;
    end else if (div_q >= div_lim - 4'd1) begin
      div_q <= 4'd0;
    end else begin
      div_q <= div_q + 4'd1;
    end
  end

  // Cycle strobe shared by the core and the serial fixed-rate modes
  assign mcycle_en       = mc;
  assign serial_fixed_en = mc;

  // Reset pin qualification over two machine cycles
  // A short glitch on the pin clears the count and never resets the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt_q    <= 2'd0;
      rst_int_q <= 1'b1;
    end else if (!reset_pin) begin
      rcnt_q    <= 2'd0;
      rst_int_q <= 1'b0;
    end else if (mc && rcnt_q != `CRPC_RST_MCYC) begin
      rcnt_q    <= rcnt_q + 2'd1;
    end else if (rcnt_q == `CRPC_RST_MCYC) begin
      rst_int_q <= 1'b1;
    end
  end

  // Port force is combinational so ports react without a clock
  assign core_reset        = rst_int_q;
  assign ports_reset_force = reset_pin | ~presetn;

  // Strap and test mode capture at reset release
  // Sampled one clock after internal reset falls, so all three pins are settled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_prev_q <= 1'b1;
      ea_q       <= 1'b0;
      test_q     <= 1'b0;
    end else begin
      rst_prev_q <= rst_int_q;
      if (rst_prev_q && !rst_int_q) begin
        ea_q   <= external_access_strap;
        test_q <= ~ale_pin_in & program_store_strobe_in;
      end else if (rst_int_q) begin
        test_q <= 1'b0;
      end
    end
  end

  // Test mode releases port 0 and weakly lifts the other pins
  assign ea_latched     = ea_q;
  assign test_mode      = test_q;
  assign port0_float    = test_q;
  assign weak_pullup_en = test_q;

  // Per-pin wake terms; only enabled level-mode pins take part
  assign irq_pin_lvl = {ext_irq_pin_one, ext_irq_pin_zero};
  for (genvar g = 0; g < 2; g++) begin : g_wake
    // Armed pin held low asks for an oscillator restart
    assign pin_low[g]   = ext_irq_enable[g] & ext_irq_level_mode[g] & ~irq_pin_lvl[g];
    // Unarmed pins never hold back the exit
    assign pin_clear[g] = ~ext_irq_enable[g] | ~ext_irq_level_mode[g] | irq_pin_lvl[g];
  end

  // Any armed pin low restarts; all back high completes the exit
  assign wake_low  = |pin_low;
  assign wake_high = &pin_clear;

  // Power-mode sequencer
  // Power-down beats idle when software sets both request bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= CRPC_RUN;
      stall_q <= 2'd0;
    end else begin
      case (st_q)
        // Normal execution; software requests a low-power mode
        CRPC_RUN: begin
          if (wr && paddr == `CRPC_OFF_PWRCTL && pwdata[`CRPC_BIT_PDOWN]) begin
            st_q <= CRPC_PDOWN;
          end else if (wr && paddr == `CRPC_OFF_PWRCTL && pwdata[`CRPC_BIT_IDLE]) begin
            st_q <= CRPC_IDLE;
          end
        end
        // Core asleep, peripherals and oscillator running
        CRPC_IDLE: begin
          if (reset_pin) begin
            st_q    <= CRPC_STALL;
            stall_q <= 2'd0;
          end else if (irq_pending) begin
            st_q <= CRPC_RUN;
          end
        end
        // Run on briefly until the qualified reset takes over
        CRPC_STALL: begin
          if (rst_int_q) begin
            st_q <= CRPC_RUN;
          end else if (!reset_pin) begin
            st_q <= CRPC_IDLE;                   // pulse too short to reset
          end else if (mc && stall_q != `CRPC_STALL_MCYC) begin
            stall_q <= stall_q + 2'd1;
          end
        end
        // Oscillator stopped; reset or an armed pin restarts it
        CRPC_PDOWN: begin
          if (reset_pin) begin
            st_q <= CRPC_RUN;
          end else if (wake_low) begin
            st_q <= CRPC_WAKE;
          end
        end
        // Oscillator back; wait for every armed pin to return high
        CRPC_WAKE: begin
          if (reset_pin || wake_high) begin
            st_q <= CRPC_RUN;
          end
        end
        default: st_q <= CRPC_RUN;
      endcase
    end
  end

  // Core keeps running through the stall window after a reset in idle
  assign cpu_run          = (st_q == CRPC_RUN) | (st_q == CRPC_STALL && stall_q != `CRPC_STALL_MCYC);
  assign ram_access_block = (st_q == CRPC_STALL);
  assign osc_enable       = (st_q != CRPC_PDOWN) | test_q;

  // Software control bits; most reset on the internal reset
  // The power-off flag lives apart so warm resets leave it alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsel_q   <= 1'b0;
      low_power_prom_bit_q   <= 1'b0;
      t2ct_q   <= 1'b0;
      t2run_q  <= 1'b0;
      clkout_output_enable_q   <= 1'b0;
      reload_q <= '0;
    end else if (rst_int_q) begin
      dsel_q   <= 1'b0;
      low_power_prom_bit_q   <= 1'b0;
      t2ct_q   <= 1'b0;
      t2run_q  <= 1'b0;
      clkout_output_enable_q   <= 1'b0;
      reload_q <= '0;
    end else if (wr) begin
      case (paddr)
        // Clock mode select
        `CRPC_OFF_CLKCFG: begin
          dsel_q <= pwdata[`CRPC_BIT_DSEL];
        end
        // Program-memory analog power
        `CRPC_OFF_AUX: begin
          low_power_prom_bit_q <= pwdata[`CRPC_BIT_LOW_POWER_PROM_BIT];
        end
        // Timer source and run
        `CRPC_OFF_T2CTL: begin
          t2ct_q  <= pwdata[`CRPC_BIT_T2CT];
          t2run_q <= pwdata[`CRPC_BIT_T2RUN];
        end
        // Clock-out pin enable
        `CRPC_OFF_T2MODE: begin
          clkout_output_enable_q <= pwdata[`CRPC_BIT_CLKOUT_OUTPUT_ENABLE];
        end
        // Reload value for the clock-out period
        `CRPC_OFF_T2RELOAD: begin
          reload_q <= pwdata[RELOAD_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Power-off flag: set by power-up, kept across warm resets
  // Software may write either level to tell cold from warm starts
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      pof_q <= 1'b1;
    end else if (wr && paddr == `CRPC_OFF_PWRCTL) begin
      pof_q <= pwdata[`CRPC_BIT_POF];
    end
  end

  assign prom_analog_off = low_power_prom_bit_q;

  // Clock-out generator: toggles per reload overflow
  // Counter is preloaded while stopped so the first half period is full
  assign clkout_mode = ~t2ct_q & clkout_output_enable_q & t2run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t2cnt_q <= '0;
      half_q  <= 1'b0;
      clk_q   <= 1'b0;
    end else if (!clkout_mode || !osc_enable) begin
      t2cnt_q <= reload_q;
      half_q  <= 1'b0;
      clk_q   <= 1'b0;
    end else begin
      half_q <= ~half_q;
      // 6-clock mode counts every clock, 12-clock mode every other clock
      if (half_q || fast) begin
        if (t2cnt_q == {RELOAD_W{1'b1}}) begin
          t2cnt_q <= reload_q;
          clk_q   <= ~clk_q;
        end else begin
          t2cnt_q <= t2cnt_q + 1'b1;
        end
      end
    end
  end

  // Pin driven only in clock-out mode and never in test mode
  assign clkout_o        = clk_q;
  assign clkout_oe       = clkout_mode & ~test_q;
  assign t2_irq_suppress = clkout_mode;

  // APB read data and response
  // Data is latched in the setup phase and stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd && !penable) begin
      case (paddr)
        // Clock mode select
        `CRPC_OFF_CLKCFG:   prdata <= {31'h0, dsel_q};
        // Power flag and current low-power mode
        `CRPC_OFF_PWRCTL:   prdata <= {27'h0, pof_q, 2'b00, st_q == CRPC_PDOWN, st_q == CRPC_IDLE};
        // Program-memory analog power
        `CRPC_OFF_AUX:      prdata <= {27'h0, low_power_prom_bit_q, 4'h0};
        // Timer run and source
        `CRPC_OFF_T2CTL:    prdata <= {29'h0, t2run_q, t2ct_q, 1'b0};
        // Clock-out pin enable
        `CRPC_OFF_T2MODE:   prdata <= {30'h0, clkout_output_enable_q, 1'b0};
        // Reload value, zero-extended
        `CRPC_OFF_T2RELOAD: prdata <= {{(32-RELOAD_W){1'b0}}, reload_q};
        // Live status snapshot
        `CRPC_OFF_STATUS:   prdata <= {27'h0, test_q, ea_q, fast, osc_enable, cpu_run};
        // Anything else reads as zero
        default:            prdata <= 32'h0;
      endcase
    end
  end

  // Zero wait states; unmapped or misaligned accesses flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr > `CRPC_OFF_STATUS || paddr[1:0] != 2'b00);
endmodule : crpc_top
`default_nettype wire

/* File: dv/crpc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module crpc_chk (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Pins and wake controls
  input wire logic       reset_pin,
  input wire logic       double_speed_fuse,
  input wire logic       ext_irq_pin_zero,
  input wire logic       ext_irq_pin_one,
  input wire logic [1:0] ext_irq_enable,
  input wire logic [1:0] ext_irq_level_mode,
  // Observed outputs
  input wire logic       mcycle_en,
  input wire logic       serial_fixed_en,
  input wire logic       osc_enable,
  input wire logic       core_reset,
  input wire logic       ports_reset_force,
  input wire logic       ea_latched,
  input wire logic       test_mode,
  input wire logic       port0_float,
  input wire logic       weak_pullup_en
);
  logic [7:0] rp_q;
  logic       wake_any;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An enabled level-mode pin held low
  assign wake_any = (ext_irq_enable[0] & ext_irq_level_mode[0] & ~ext_irq_pin_zero) |
                    (ext_irq_enable[1] & ext_irq_level_mode[1] & ~ext_irq_pin_one);
  // Clocks the reset pin has stayed high with the oscillator running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rp_q <= 8'h00;
    else if (!reset_pin) rp_q <= 8'h00;
    else if (osc_enable && rp_q != 8'hff) rp_q <= rp_q + 8'h01;
  end
  AST_PORT_FORCE: assert property (reset_pin |-> ports_reset_force)
    else $error("Ports not forced by reset pin");
  AST_FAST_MCYC: assert property (double_speed_fuse && mcycle_en |=> !mcycle_en [*5] ##1 mcycle_en)
    else $error("Machine cycle not six clocks with fuse set");
  AST_SERIAL_DIV: assert property (serial_fixed_en == mcycle_en)
    else $error("Serial fixed-rate enable differs from machine cycle");
  AST_RESET_TAKES: assert property (rp_q > 8'h19 |-> core_reset)
    else $error("Reset pin held two machine cycles without reset");
  AST_STRAP_HOLD: assert property (!core_reset && $past(!core_reset) && $past(!core_reset, 2) |-> $stable(ea_latched))
    else $error("Strap latch changed outside reset");
  AST_WAKE_PIN: assert property (!osc_enable && wake_any |-> ##[0:2] osc_enable)
    else $error("Enabled level pin did not restart oscillator");
  AST_NO_WAKE: assert property (!osc_enable && !reset_pin && !wake_any |=> !osc_enable)
    else $error("Oscillator restarted without a wake source");
  AST_TEST_PINS: assert property (test_mode |-> port0_float && weak_pullup_en && osc_enable)
    else $error("Test mode pin states wrong");
endmodule : crpc_chk
bind crpc_top crpc_chk u_chk (.*);
`default_nettype wire

/* File: dv/crpc_far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module crpc_far_side (
  // Clock and commands
  input wire logic       pclk,
  input wire logic       rst_go,
  input wire logic [7:0] rst_len,
  input wire logic       wake_go,
  input wire logic       test_req,
  // Pins toward the device
  output logic           reset_pin,
  output logic           ext_irq_pin_zero,
  output logic           ext_irq_pin_one,
  output logic           ale_pin_in,
  output logic           program_store_strobe_in
);
  logic [7:0] rcnt_q = 8'h00;
  logic [7:0] wcnt_q = 8'h00;
  // Reset held high for the commanded length in clocks, with no lower limit applied
  always_ff @(posedge pclk) begin
    if (rst_go) rcnt_q <= rst_len;
    else if (rcnt_q != 8'h00) rcnt_q <= rcnt_q - 8'h01;
  end
  // Wake level held long enough for the oscillator to settle
  always_ff @(posedge pclk) begin
    if (wake_go) wcnt_q <= 8'h28;
    else if (wcnt_q != 8'h00) wcnt_q <= wcnt_q - 8'h01;
  end
  // Pulled-up pins rest high; latch pin low requests test mode
  assign reset_pin = (rcnt_q != 8'h00);
  assign ext_irq_pin_zero = (wcnt_q == 8'h00);
  assign ext_irq_pin_one = 1'b1;
  assign ale_pin_in = ~test_req;
  assign program_store_strobe_in = 1'b1;
endmodule : crpc_far_side
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import crpc_pkg::*;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, p;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, lfsr = 32'h0cae, prdata;
  logic double_speed_fuse = 0, external_access_strap = 0, irq_pending = 0, rst_go = 0, wake_go = 0, test_req = 0;
  logic [1:0] ext_irq_enable = '0, ext_irq_level_mode = '0;
  logic [7:0] rst_len = 8'h1c;
  logic pready, pslverr, reset_pin, ale_pin_in, program_store_strobe_in, ext_irq_pin_zero, ext_irq_pin_one;
  logic mcycle_en, serial_fixed_en, cpu_run, ram_access_block, osc_enable, core_reset, ports_reset_force;
  logic ea_latched, test_mode, port0_float, weak_pullup_en, prom_analog_off, t2_irq_suppress, clkout_o, clkout_oe;
  logic [32:0] exp_q[$];
  int n_fail = 0, n_compared = 0, cyc = 0, k, blk;
  crpc_top u_dut (.*);
  crpc_far_side u_far (.*);
  // Clock and hang guard
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end
  // Read monitor takes the oldest expected note
  always @(posedge pclk) if (psel && penable && pready && !pwrite) chk("read", {pslverr, prdata}, exp_q.pop_front());
  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  // One APB transfer, held until pready, settled at the falling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(negedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, '0);
  endtask : rd
  task automatic rst(input logic f);
    presetn <= 0; double_speed_fuse <= f;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 60 && core_reset !== 0; k++) @(posedge pclk);
  endtask : rst
  // Reset pin pulse of random length; notes a RAM block before reset acts
  task automatic prst();
    lfsr = nx(lfsr); blk = 0;
    @(posedge pclk);
    rst_go <= 1; rst_len <= 8'h1c + lfsr[3:0];
    @(posedge pclk);
    rst_go <= 0;
    for (k = 0; k < 80 && core_reset !== 1; k++) @(posedge pclk) if (ram_access_block === 1) blk = 1;
    for (k = 0; k < 80 && core_reset !== 0; k++) @(posedge pclk);
    @(negedge pclk);
  endtask : prst
  initial begin
    repeat (2) @(posedge pclk);
    por_n <= 1;
    rst(0);
    rd(12'h004, 33'h10);
    apb(1, 12'h004, '0); rd(12'h004, 33'h0);
    rd(12'h020, 33'h100000000);
    // Clock modes: slow, select bit, fuse
    for (int f = 0; f < 3; f++) begin
      rst(f == 2);
      apb(1, 12'h000, f == 1);
      @(posedge pclk iff mcycle_en === 1);
      k = 0;
      do begin @(posedge pclk); k++; end while (mcycle_en !== 1 && k < 40);
      chk("mcycle", k, f ? 6 : 12);
      rd(12'h018, {30'h0, f != 0, 2'h3});
      lfsr = nx(lfsr);
      apb(1, 12'h014, {16'h0, 12'hfff, lfsr[3:0]});
      apb(1, 12'h010, 32'h2); apb(1, 12'h00c, 32'h4);
      chk("oe", clkout_oe, 1);
      chk("t2irq", t2_irq_suppress, 1);
      p = clkout_o;
      @(posedge pclk iff clkout_o !== p);
      p = clkout_o; k = 0;
      do begin @(posedge pclk); k++; end while (clkout_o === p && k < 100);
      chk("half", k, (f ? 1 : 2) * (16 - lfsr[3:0]));
      apb(1, 12'h00c, 32'h6); chk("oe", clkout_oe, 0);
    end
    apb(1, 12'h000, 32'h1);
    prst(); rd(12'h000, 33'h0);
    rst(0);
    apb(1, 12'h008, 32'h10); chk("low_power_prom_bit", prom_analog_off, 1);
    apb(1, 12'h004, 32'h1); chk("idle", cpu_run, 0);
    chk("osc", osc_enable, 1);
    irq_pending <= 1;
    for (k = 0; k < 50 && cpu_run !== 1; k++) @(posedge pclk);
    chk("idle exit", cpu_run, 1);
    irq_pending <= 0; ext_irq_enable <= 2'h1; ext_irq_level_mode <= 2'h1;
    apb(1, 12'h004, 32'h2); chk("pdown", osc_enable, 0);
    wake_go <= 1; @(posedge pclk); wake_go <= 0;
    for (k = 0; k < 100 && osc_enable !== 1; k++) @(posedge pclk);
    chk("wake", osc_enable, 1);
    for (k = 0; k < 100 && cpu_run !== 1; k++) @(posedge pclk);
    chk("resume", cpu_run, 1);
    rd(12'h008, 33'h10);
    apb(1, 12'h004, 32'h1); external_access_strap <= 1;
    prst(); chk("stall", blk, 1);
    external_access_strap <= 0;
    rd(12'h008, 33'h0);
    rd(12'h018, 33'h0b);
    chk("ea", ea_latched, 1);
    test_req <= 1;
    prst(); chk("test", test_mode, 1);
    test_req <= 0;
    prst(); chk("test", test_mode, 0);
    test_done();
  end
endmodule : tb
`default_nettype wire
